// ==== verilog/cid_regs.svh ====
// Purpose: constants of the instruction decoder
// Assumes: opcode byte in bits 7:0, bit 7 set for the long form
// Notes: opcode values are local to this core
`ifndef CID_REGS_SVH
`define CID_REGS_SVH
// Instruction field positions
`define CID_LEN_BIT 7
`define CID_OP_LSB 0
`define CID_RA_LSB 8
`define CID_RB_LSB 12
`define CID_IMM_LSB 16
`define CID_BITJ_LSB 8
`define CID_BITX_LSB 16
`define CID_BITY_LSB 24
`define CID_MASK_LSB 16
`define CID_DATA_LSB 24
`define CID_TRAPNO_LSB 8
`define CID_SEG_LSB 8
`define CID_XCNT_LSB 8
`define CID_HALF_BIT 12
// Instruction lengths in bytes
`define CID_LEN_SHORT 3'h2
`define CID_LEN_LONG 3'h4
// Opcodes, low seven bits
`define CID_OP_NOP 7'h00
`define CID_OP_ADDC 7'h01
`define CID_OP_ADDCB 7'h02
`define CID_OP_SUBC 7'h03
`define CID_OP_SUBCB 7'h04
`define CID_OP_MULT_S 7'h05
`define CID_OP_MULT_U 7'h06
`define CID_OP_DIVIDE_S 7'h07
`define CID_OP_DIVIDE_U 7'h08
`define CID_OP_LDIVIDE_S 7'h09
`define CID_OP_LDIVIDE_U 7'h0A
`define CID_OP_CMP_DEC1 7'h0B
`define CID_OP_CMP_DEC2 7'h0C
`define CID_OP_CMP_INC1 7'h0D
`define CID_OP_CMP_INC2 7'h0E
`define CID_OP_NORM 7'h0F
`define CID_OP_SHR_ARITH 7'h10
`define CID_OP_EXT_SIGN 7'h11
`define CID_OP_EXT_ZERO 7'h12
`define CID_OP_BR_BIT 7'h13
`define CID_OP_BR_BIT_CLR 7'h14
`define CID_OP_FIELD_HI 7'h15
`define CID_OP_FIELD_LO 7'h16
`define CID_OP_BIT_COPY 7'h17
`define CID_OP_BIT_COPY_INV 7'h18
`define CID_OP_BIT_CMP 7'h19
`define CID_OP_SLEEP 7'h1A
`define CID_OP_TRAP 7'h1B
`define CID_OP_CTX_SWITCH 7'h1C
`define CID_OP_PUSH_CALL 7'h1D
`define CID_OP_RETURN 7'h1E
`define CID_OP_RETURN_POP 7'h1F
`define CID_OP_SEG_JUMP 7'h20
`define CID_OP_EXT_PAGE 7'h21
`define CID_OP_EXT_PAGE_REG 7'h22
`define CID_OP_ACC_LOAD 7'h23
`define CID_OP_ACC_STORE 7'h24
// Reset values
`define CID_RST_WORD 16'h0000
`define CID_RST_SEG 8'h00
`define CID_RST_SP 4'h0
`define CID_RST_ACC 32'h0000_0000
`endif

// ==== verilog/cid_pkg.sv ====
// Purpose: types shared by the instruction decoder
// Assumes: constants live in cid_regs.svh
// Notes: none
package cid_pkg;
  typedef struct packed {
    logic valid;
    logic [31:0] word;
  } cid_fetch_type;
  typedef struct packed {
    logic c;
    logic z;
    logic n;
    logic v;
  } cid_flags_type;
  typedef struct packed {
    logic retire;
    logic illegal;
    logic trap;
    logic [2:0] len;
    logic [7:0] seg;
    logic [15:0] pc;
    logic [3:0] sp;
    cid_flags_type flags;
    logic [2:0] ext_left;
    logic ext_reg;
    logic [9:0] ext_page;
    logic [31:0] acc;
    logic [15:0] md_hi;
    logic [15:0] md_lo;
  } cid_status_type;
endpackage

// ==== verilog/cid_decoder.sv ====
////////////////////////////////////////////////////////////////////////////////
// Purpose: decode and execute one fetched instruction per cycle
// Assumes: fetch presents a whole 2- or 4-byte instruction at once
// Notes: every instruction completes in the cycle it is accepted
// Summary of operation
// - signed and unsigned 16x16 register multiply
// - 16/16 divide of low muldiv register
// - 32/16 long divide of muldiv pair
// - add/subtract with carry, word/byte, both lengths
// - compare then step register by one/two
// - normalize count written to another register
// - arithmetic right shift keeps sign bit
// - byte to word move, sign/zero extend
// - branch on set bit, optionally clear it
// - masked high/low byte field update
// - copy bit to bit, optionally inverted
// - compare one bit with another
// - legacy sleep opcode decodes, does nothing
// - trap enters routine by immediate number
// - context switch: push, then load register
// - push register, then call absolute address
// - near return, optionally popping a register
// - jump absolute into any code segment
// - extended page prefix, optional register mode
// - accumulator load and register store
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`include "cid_regs.svh"
module cid_decoder (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire cid_pkg::cid_fetch_type fetch_in,
  output logic fetch_ready,
  input wire logic [3:0] dbg_sel,
  output logic [15:0] dbg_data,
  output cid_pkg::cid_status_type status
);
  import cid_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State registers and next values
  logic [15:0] gpr_r [16];
  logic [15:0] gpr_nxt [16];
  logic [15:0] bmem_r [16];
  logic [15:0] bmem_nxt [16];
  logic [15:0] stk_r [16];
  logic [15:0] stk_nxt [16];
  logic [3:0] sp_r, sp_nxt;
  logic [15:0] pc_r, pc_nxt;
  logic [7:0] seg_r, seg_nxt;
  cid_flags_type flg_r, flg_nxt;
  logic [15:0] mdh_r, mdh_nxt, mdl_r, mdl_nxt;
  logic [31:0] acc_r, acc_nxt;
  logic [2:0] xl_r, xl_nxt;
  logic xr_r, xr_nxt;
  logic [9:0] xp_r, xp_nxt;
  logic ret_r, ret_nxt, ill_r, ill_nxt, trp_r, trp_nxt;
  logic [2:0] len_r, len_nxt;
  logic [15:0] dbg_r, dbg_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Field extraction from the fetched word
  logic [31:0] w;
  logic [6:0] op;
  logic four, legal, fire, a_msb;
  logic [1:0] lc;
  logic [3:0] ra, rb, bjw, bjp;
  logic [15:0] imm, a, b, opnd, seq_pc, br_tgt, dv, trap_vec;
  assign w = fetch_in.word;
  assign op = w[`CID_OP_LSB +: 7];
  assign four = w[`CID_LEN_BIT];
  assign ra = w[`CID_RA_LSB +: 4];
  assign rb = w[`CID_RB_LSB +: 4];
  assign imm = w[`CID_IMM_LSB +: 16];
  assign a = gpr_r[ra];
  assign b = gpr_r[rb];
  assign a_msb = a[15];
  // Long forms take the immediate, short forms the second register
  assign opnd = four ? imm : b;
  assign seq_pc = pc_r + (four ? 16'h0004 : 16'h0002);
  assign br_tgt = seq_pc + {imm[14:0], 1'b0};
  assign trap_vec = {7'h00, w[`CID_TRAPNO_LSB +: 7], 2'h0};
  assign bjw = w[`CID_BITJ_LSB +: 4];
  assign bjp = w[`CID_BITJ_LSB + 4 +: 4];

  // Legal lengths per opcode: bit 0 short form, bit 1 long form
  function automatic logic [1:0] len_class(input logic [6:0] opc);
    case (opc)
      `CID_OP_NOP, `CID_OP_MULT_S, `CID_OP_MULT_U, `CID_OP_DIVIDE_S,
      `CID_OP_DIVIDE_U, `CID_OP_LDIVIDE_S, `CID_OP_LDIVIDE_U, `CID_OP_NORM,
      `CID_OP_SHR_ARITH, `CID_OP_TRAP, `CID_OP_RETURN,
      `CID_OP_RETURN_POP: len_class = 2'h1;
      `CID_OP_ADDC, `CID_OP_ADDCB, `CID_OP_SUBC, `CID_OP_SUBCB,
      `CID_OP_CMP_DEC1, `CID_OP_CMP_DEC2, `CID_OP_CMP_INC1, `CID_OP_CMP_INC2,
      `CID_OP_EXT_SIGN, `CID_OP_EXT_ZERO, `CID_OP_EXT_PAGE,
      `CID_OP_EXT_PAGE_REG: len_class = 2'h3;
      `CID_OP_BR_BIT, `CID_OP_BR_BIT_CLR, `CID_OP_FIELD_HI, `CID_OP_FIELD_LO,
      `CID_OP_BIT_COPY, `CID_OP_BIT_COPY_INV, `CID_OP_BIT_CMP, `CID_OP_SLEEP,
      `CID_OP_CTX_SWITCH, `CID_OP_PUSH_CALL, `CID_OP_SEG_JUMP,
      `CID_OP_ACC_LOAD, `CID_OP_ACC_STORE: len_class = 2'h2;
      default: len_class = 2'h0;
    endcase
  endfunction

  // Shifts needed to bring the top set bit to bit 15
  function automatic logic [15:0] norm_cnt(input logic [15:0] v);
    norm_cnt = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      if (v[i]) norm_cnt = 16'(15 - i);
    end
  endfunction

  assign lc = len_class(op);
  assign legal = lc[four];
  assign fire = ce && fetch_in.valid && legal;
  assign fetch_ready = ce;

  ////////////////////////////////////////////////////////////////////////////
  // Datapath results
  logic [16:0] asum, ssum, cmp;
  logic [8:0] absum, sbsum;
  logic [31:0] mdw, prod_s, prod_u, lq_s, lr_s, lq_u, lr_u;
  logic [15:0] q_s, r_s, q_u, r_u;
  logic bit_j, bit_x, bit_y;
  assign asum = {1'b0, a} + {1'b0, opnd} + 17'(flg_r.c);
  assign ssum = {1'b0, a} - {1'b0, opnd} - 17'(flg_r.c);
  assign absum = {1'b0, a[7:0]} + {1'b0, opnd[7:0]} + 9'(flg_r.c);
  assign sbsum = {1'b0, a[7:0]} - {1'b0, opnd[7:0]} - 9'(flg_r.c);
  assign cmp = {1'b0, a} - {1'b0, opnd};
  assign mdw = {mdh_r, mdl_r};
  assign prod_s = $signed(a) * $signed(b);
  assign prod_u = a * b;
  // Zero divisor swapped for one; the result is discarded in that case
  assign dv = (a == 16'h0000) ? 16'h0001 : a;
  assign q_s = $signed(mdl_r) / $signed(dv);
  assign r_s = $signed(mdl_r) % $signed(dv);
  assign q_u = mdl_r / dv;
  assign r_u = mdl_r % dv;
  assign lq_s = $signed(mdw) / $signed(dv);
  assign lr_s = $signed(mdw) % $signed(dv);
  assign lq_u = mdw / {16'h0000, dv};
  assign lr_u = mdw % {16'h0000, dv};
  assign bit_j = bmem_r[bjw][bjp];
  assign bit_x = bmem_r[w[`CID_BITX_LSB +: 4]][w[`CID_BITX_LSB + 4 +: 4]];
  assign bit_y = bmem_r[w[`CID_BITY_LSB +: 4]][w[`CID_BITY_LSB + 4 +: 4]];

  ////////////////////////////////////////////////////////////////////////////
  // Execute: next values of the whole architectural state
  always_comb begin
    gpr_nxt = gpr_r;
    bmem_nxt = bmem_r;
    stk_nxt = stk_r;
    sp_nxt = sp_r;
    pc_nxt = pc_r;
    seg_nxt = seg_r;
    flg_nxt = flg_r;
    mdh_nxt = mdh_r;
    mdl_nxt = mdl_r;
    acc_nxt = acc_r;
    xl_nxt = xl_r;
    xr_nxt = xr_r;
    xp_nxt = xp_r;
    len_nxt = len_r;
    ret_nxt = 1'b0;
    ill_nxt = 1'b0;
    trp_nxt = 1'b0;
    dbg_nxt = gpr_r[dbg_sel];
    // Illegal length or code still advances, so fetch never stalls
    if (fetch_in.valid) begin
      len_nxt = four ? `CID_LEN_LONG : `CID_LEN_SHORT;
      pc_nxt = seq_pc;
      ret_nxt = legal;
      ill_nxt = !legal;
    end
    if (fire && xl_r != 3'h0) begin
      xl_nxt = xl_r - 3'h1;
    end
    if (fire) begin
      unique case (op)
        `CID_OP_ADDC: begin
          gpr_nxt[ra] = asum[15:0];
          flg_nxt.c = asum[16];
          flg_nxt.z = asum[15:0] == 16'h0000;
          flg_nxt.n = asum[15];
        end
        `CID_OP_SUBC: begin
          gpr_nxt[ra] = ssum[15:0];
          flg_nxt.c = ssum[16];
          flg_nxt.z = ssum[15:0] == 16'h0000;
          flg_nxt.n = ssum[15];
        end
        `CID_OP_ADDCB: begin
          gpr_nxt[ra] = {a[15:8], absum[7:0]};
          flg_nxt.c = absum[8];
          flg_nxt.z = absum[7:0] == 8'h00;
          flg_nxt.n = absum[7];
        end
        `CID_OP_SUBCB: begin
          gpr_nxt[ra] = {a[15:8], sbsum[7:0]};
          flg_nxt.c = sbsum[8];
          flg_nxt.z = sbsum[7:0] == 8'h00;
          flg_nxt.n = sbsum[7];
        end
        `CID_OP_MULT_S, `CID_OP_MULT_U: begin
          {mdh_nxt, mdl_nxt} = (op == `CID_OP_MULT_S) ? prod_s : prod_u;
        end
        `CID_OP_DIVIDE_S, `CID_OP_DIVIDE_U, `CID_OP_LDIVIDE_S,
        `CID_OP_LDIVIDE_U: begin
          // Zero divisor leaves the muldiv pair untouched and flags overflow
          flg_nxt.v = a == 16'h0000;
          if (a != 16'h0000) begin
            unique case (op)
              `CID_OP_DIVIDE_S: {mdh_nxt, mdl_nxt} = {r_s, q_s};
              `CID_OP_DIVIDE_U: {mdh_nxt, mdl_nxt} = {r_u, q_u};
              `CID_OP_LDIVIDE_S: {mdh_nxt, mdl_nxt} = {lr_s[15:0], lq_s[15:0]};
              default: {mdh_nxt, mdl_nxt} = {lr_u[15:0], lq_u[15:0]};
            endcase
          end
        end
        `CID_OP_CMP_DEC1, `CID_OP_CMP_DEC2, `CID_OP_CMP_INC1,
        `CID_OP_CMP_INC2: begin
          // Flags reflect the value before the step
          flg_nxt.c = cmp[16];
          flg_nxt.z = cmp[15:0] == 16'h0000;
          flg_nxt.n = cmp[15];
          unique case (op)
            `CID_OP_CMP_DEC1: gpr_nxt[ra] = a - 16'h0001;
            `CID_OP_CMP_DEC2: gpr_nxt[ra] = a - 16'h0002;
            `CID_OP_CMP_INC1: gpr_nxt[ra] = a + 16'h0001;
            default: gpr_nxt[ra] = a + 16'h0002;
          endcase
        end
        `CID_OP_NORM: begin
          gpr_nxt[ra] = norm_cnt(b);
          flg_nxt.z = b == 16'h0000;
        end
        `CID_OP_SHR_ARITH: begin
          gpr_nxt[ra] = $signed(a) >>> b[3:0];
        end
        `CID_OP_EXT_SIGN: begin
          gpr_nxt[ra] = {{8{opnd[7]}}, opnd[7:0]};
        end
        `CID_OP_EXT_ZERO: begin
          gpr_nxt[ra] = {8'h00, opnd[7:0]};
        end
        `CID_OP_BR_BIT, `CID_OP_BR_BIT_CLR: begin
          if (bit_j) begin
            pc_nxt = br_tgt;
            if (op == `CID_OP_BR_BIT_CLR) bmem_nxt[bjw][bjp] = 1'b0;
          end
        end
        `CID_OP_FIELD_HI: begin
          bmem_nxt[ra][15:8] = (bmem_r[ra][15:8] & ~w[`CID_MASK_LSB +: 8])
            | (w[`CID_DATA_LSB +: 8] & w[`CID_MASK_LSB +: 8]);
        end
        `CID_OP_FIELD_LO: begin
          bmem_nxt[ra][7:0] = (bmem_r[ra][7:0] & ~w[`CID_MASK_LSB +: 8])
            | (w[`CID_DATA_LSB +: 8] & w[`CID_MASK_LSB +: 8]);
        end
        `CID_OP_BIT_COPY, `CID_OP_BIT_COPY_INV: begin
          bmem_nxt[w[`CID_BITX_LSB +: 4]][w[`CID_BITX_LSB + 4 +: 4]] =
            bit_y ^ (op == `CID_OP_BIT_COPY_INV);
        end
        `CID_OP_BIT_CMP: begin
          flg_nxt.z = bit_x == bit_y;
          flg_nxt.n = bit_x;
          flg_nxt.c = bit_y;
        end
        `CID_OP_SLEEP: begin
          // Kept only for old code; the power scheme lives elsewhere
          pc_nxt = seq_pc;
        end
        `CID_OP_TRAP: begin
          stk_nxt[sp_r] = seq_pc;
          sp_nxt = sp_r + 4'h1;
          pc_nxt = trap_vec;
          seg_nxt = `CID_RST_SEG;
          trp_nxt = 1'b1;
        end
        `CID_OP_CTX_SWITCH: begin
          stk_nxt[sp_r] = a;
          sp_nxt = sp_r + 4'h1;
          gpr_nxt[ra] = opnd;
        end
        `CID_OP_PUSH_CALL: begin
          stk_nxt[sp_r] = a;
          stk_nxt[4'(sp_r + 4'h1)] = seq_pc;
          sp_nxt = sp_r + 4'h2;
          pc_nxt = imm;
        end
        `CID_OP_RETURN: begin
          pc_nxt = stk_r[4'(sp_r - 4'h1)];
          sp_nxt = sp_r - 4'h1;
        end
        `CID_OP_RETURN_POP: begin
          pc_nxt = stk_r[4'(sp_r - 4'h1)];
          gpr_nxt[ra] = stk_r[4'(sp_r - 4'h2)];
          sp_nxt = sp_r - 4'h2;
        end
        `CID_OP_SEG_JUMP: begin
          seg_nxt = w[`CID_SEG_LSB +: 8];
          pc_nxt = imm;
        end
        `CID_OP_EXT_PAGE, `CID_OP_EXT_PAGE_REG: begin
          xl_nxt = {1'b0, w[`CID_XCNT_LSB +: 2]} + 3'h1;
          xr_nxt = op == `CID_OP_EXT_PAGE_REG;
          xp_nxt = four ? imm[9:0] : b[9:0];
        end
        `CID_OP_ACC_LOAD: begin
          acc_nxt = {imm, a};
        end
        `CID_OP_ACC_STORE: begin
          gpr_nxt[ra] = w[`CID_HALF_BIT] ? acc_r[31:16] : acc_r[15:0];
        end
        default: begin
        end
      endcase
    end
    if (xl_nxt == 3'h0) xr_nxt = 1'b0;
  end

  // Register stage; low clock enable freezes everything
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 16; i++) begin
        gpr_r[i] <= `CID_RST_WORD;
        bmem_r[i] <= `CID_RST_WORD;
        stk_r[i] <= `CID_RST_WORD;
      end
      sp_r <= `CID_RST_SP;
      pc_r <= `CID_RST_WORD;
      seg_r <= `CID_RST_SEG;
      flg_r <= '0;
      mdh_r <= `CID_RST_WORD;
      mdl_r <= `CID_RST_WORD;
      acc_r <= `CID_RST_ACC;
      xl_r <= 3'h0;
      xr_r <= 1'b0;
      xp_r <= 10'h000;
      len_r <= `CID_LEN_SHORT;
      ret_r <= 1'b0;
      ill_r <= 1'b0;
      trp_r <= 1'b0;
      dbg_r <= `CID_RST_WORD;
    end else if (ce) begin
      gpr_r <= gpr_nxt;
      bmem_r <= bmem_nxt;
      stk_r <= stk_nxt;
      sp_r <= sp_nxt;
      pc_r <= pc_nxt;
      seg_r <= seg_nxt;
      flg_r <= flg_nxt;
      mdh_r <= mdh_nxt;
      mdl_r <= mdl_nxt;
      acc_r <= acc_nxt;
      xl_r <= xl_nxt;
      xr_r <= xr_nxt;
      xp_r <= xp_nxt;
      len_r <= len_nxt;
      ret_r <= ret_nxt;
      ill_r <= ill_nxt;
      trp_r <= trp_nxt;
      dbg_r <= dbg_nxt;
    end
  end

  // Status view, all from flops
  assign dbg_data = dbg_r;
  assign status = '{retire: ret_r, illegal: ill_r, trap: trp_r, len: len_r,
    seg: seg_r, pc: pc_r, sp: sp_r, flags: flg_r, ext_left: xl_r,
    ext_reg: xr_r, ext_page: xp_r, acc: acc_r, md_hi: mdh_r, md_lo: mdl_r};

  ////////////////////////////////////////////////////////////////////////////
  // Checks on executed results
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_fire(logic [6:0] opc);
    fire && op == opc;
  endsequence
  sequence s_call_then_ret;
    s_fire(`CID_OP_PUSH_CALL) ##1 s_fire(`CID_OP_RETURN_POP);
  endsequence

  a_mult_signed: assert property (s_fire(`CID_OP_MULT_S) |=>
    $signed({mdh_r, mdl_r}) == $signed($past(a)) * $signed($past(b)))
    else $error("signed product wrong");
  a_div_zero: assert property (s_fire(`CID_OP_DIVIDE_U) ##0 a == 16'h0000
    |=> flg_r.v && mdl_r == $past(mdl_r) && mdh_r == $past(mdh_r))
    else $error("divide by zero altered result");
  a_long_div: assert property (s_fire(`CID_OP_LDIVIDE_U) ##0 (mdh_r < a)
    |=> $past(mdw) == {16'h0000, mdl_r} * {16'h0000, $past(a)} + {16'h0000, mdh_r}
    && mdh_r < $past(a))
    else $error("long divide inconsistent");
  a_len_both: assert property (s_fire(`CID_OP_ADDC) |=> ret_r &&
    len_r == ($past(four) ? `CID_LEN_LONG : `CID_LEN_SHORT))
    else $error("length of carry add wrong");
  a_cmp_dec2: assert property (s_fire(`CID_OP_CMP_DEC2) |=>
    gpr_r[$past(ra)] == $past(a) - 16'h0002 && flg_r.z == ($past(cmp[15:0]) == 16'h0000))
    else $error("compare step wrong");
  a_norm_msb: assert property (s_fire(`CID_OP_NORM) ##0 (b != 16'h0000)
    |=> ($past(b) >> (4'hF - gpr_r[$past(ra)][3:0])) == 16'h0001)
    else $error("normalize count wrong");
  a_shr_sign: assert property (s_fire(`CID_OP_SHR_ARITH) ##0 (ra != rb)
    |=> gpr_r[$past(ra)][15] == $past(a_msb))
    else $error("sign not kept");
  a_jump_clear: assert property (s_fire(`CID_OP_BR_BIT_CLR) ##0 bit_j
    |=> pc_r == $past(br_tgt) && !bmem_r[$past(bjw)][$past(bjp)])
    else $error("bit branch wrong");
  a_sleep_inert: assert property (s_fire(`CID_OP_SLEEP) |=> ret_r &&
    pc_r == $past(seq_pc) && sp_r == $past(sp_r) && flg_r == $past(flg_r)
    && acc_r == $past(acc_r) && mdw == $past(mdw))
    else $error("sleep opcode had effect");
  a_trap_vector: assert property (s_fire(`CID_OP_TRAP) |=> trp_r &&
    pc_r == $past(trap_vec) && sp_r == $past(sp_r) + 4'h1)
    else $error("trap entry wrong");
  a_call_push: assert property (s_fire(`CID_OP_PUSH_CALL) |=>
    pc_r == $past(imm) && sp_r == $past(sp_r) + 4'h2 && stk_r[$past(sp_r)] == $past(a))
    else $error("push and call wrong");
  a_return_pop: assert property (s_call_then_ret |=>
    pc_r == $past(seq_pc, 2) && sp_r == $past(sp_r, 2))
    else $error("return did not restore");
endmodule

// ==== test/cid_fetch_model.sv ====
// Purpose: program memory fetch path feeding the decoder
// Assumes: one whole instruction word per request
// Notes: word bus is zero before the first request and shows inverted data after each request
`timescale 1ns/1ps
module cid_fetch_model (
  input wire logic clk,
  input wire logic fetch_ready,
  output cid_pkg::cid_fetch_type fetch_in
);
  import cid_pkg::*;
  initial begin
    fetch_in = '0;
  end
  // Stall gap cycles, then hold the word until ready is sampled high, giving up after 16 edges
  task automatic send(input logic [31:0] wd, input int gap, output logic ok);
    ok = 1'b0;
    repeat (gap) @(posedge clk);
    @(posedge clk);
    #1;
    fetch_in.valid = 1'b1;
    fetch_in.word = wd;
    for (int i = 0; i < 16 && !ok; i++) begin
      @(posedge clk);
      ok = (fetch_ready === 1'b1);
    end
    #1;
    // Released bus must not look like a stale copy of the word
    fetch_in.valid = 1'b0;
    fetch_in.word = ~wd;
  endtask
  // Two words on consecutive edges; ready must stand at both, else a word is lost
  task automatic send2(input logic [31:0] w0, input logic [31:0] w1, output logic ok);
    @(posedge clk);
    #1;
    fetch_in.valid = 1'b1;
    fetch_in.word = w0;
    @(posedge clk);
    ok = (fetch_ready === 1'b1);
    #1;
    fetch_in.word = w1;
    @(posedge clk);
    ok = ok && (fetch_ready === 1'b1);
    #1;
    fetch_in.valid = 1'b0;
    fetch_in.word = ~w1;
  endtask
endmodule

// ==== test/cid_decoder_tb.sv ====
// Purpose: self-checking bench of the instruction decoder
// Assumes: flags and registers are zero after reset
// Notes: register contents are read back through the debug port
`timescale 1ns/1ps
`include "cid_regs.svh"
module cid_decoder_tb;
  import cid_pkg::*;
  logic clk;
  logic rst_n;
  logic ce;
  logic fetch_ready;
  logic [3:0] dbg_sel;
  logic [15:0] dbg_data;
  cid_fetch_type fetch_in;
  cid_status_type status;
  int num_errors;
  int check_count;
  logic [29:0] notes[$];
  logic [15:0] pc;
  logic [7:0] seg;
  logic [15:0] a, b, q, r, n, sgt;
  logic [31:0] p;
  logic [6:0] num;
  logic ok2;
  logic [15:0] ai[3] = '{16'hFFFF, 16'h0001, 16'h0002};
  logic [15:0] ar[3] = '{16'hFFFF, 16'h0000, 16'h0003};
  logic [1:0] acz[3] = '{2'b00, 2'b11, 2'b00};

  cid_decoder cid_decoder_inst (.clk(clk), .rst_n(rst_n), .ce(ce), .fetch_in(fetch_in),
    .fetch_ready(fetch_ready), .dbg_sel(dbg_sel), .dbg_data(dbg_data), .status(status));
  cid_fetch_model cid_fetch_model_inst (.clk(clk), .fetch_ready(fetch_ready),
    .fetch_in(fetch_in));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [31:0] w(input logic [6:0] op, input logic lg,
    input logic [3:0] ra, input logic [3:0] rb, input logic [15:0] imm);
    return {imm, rb, ra, lg, op};
  endfunction
  // Note the expected status, hand the word over, let the result land
  task automatic exj(input logic [31:0] wd, input logic ill, input logic trp,
    input logic [15:0] npc);
    logic ok;
    notes.push_back({~ill, ill, trp, (wd[7] ? 3'h4 : 3'h2), seg, npc});
    pc = npc;
    cid_fetch_model_inst.send(wd, $urandom % 3, ok);
    if (!ok) begin
      num_errors++;
      stop_test();
    end
    @(negedge clk);
    #1;
  endtask
  task automatic ex(input logic [31:0] wd);
    exj(wd, 1'b0, 1'b0, pc + (wd[7] ? 16'h0004 : 16'h0002));
  endtask
  task automatic rd(input logic [3:0] sel, input logic [15:0] e);
    @(posedge clk);
    #1;
    dbg_sel = sel;
    @(posedge clk);
    @(negedge clk);
    chk("dbg_data", {16'h0, e}, {16'h0, dbg_data});
  endtask
  // Result watcher: every retire or illegal pulse consumes the oldest note
  always @(negedge clk) begin
    if (rst_n === 1'b1 && (status.retire === 1'b1 || status.illegal === 1'b1)) begin
      if (notes.size() == 0) begin
        chk("unexpected result", 32'h0, 32'h1);
      end else begin
        chk("status", {2'b00, notes.pop_front()}, {2'b00, status.retire, status.illegal,
          status.trap, status.len, status.seg, status.pc});
      end
    end
  end
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    stop_test();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    ce = 1'b0;
    dbg_sel = 4'h0;
    pc = 16'h0000;
    seg = 8'h00;
    num_errors = 0;
    check_count = 0;
    void'($urandom(32'hc4b6));
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'b1;
    ce = 1'b1;
    // Carry chain through long add-with-carry
    for (int i = 0; i < 3; i++) begin
      ex(w(`CID_OP_ADDC, 1'b1, 4'h3, 4'h0, ai[i]));
      chk("flags", {30'h0, acz[i]}, {30'h0, status.flags.c, status.flags.z});
      rd(4'h3, ar[i]);
    end
    // Compare equal, then step down by two
    ex(w(`CID_OP_CMP_DEC2, 1'b1, 4'h3, 4'h0, 16'h0003));
    chk("flags", 32'h1, {30'h0, status.flags.c, status.flags.z});
    rd(4'h3, 16'h0001);
    a = 16'($urandom) | 16'h0001;
    b = 16'($urandom);
    ex(w(`CID_OP_CTX_SWITCH, 1'b1, 4'h1, 4'h0, a));
    ex(w(`CID_OP_CTX_SWITCH, 1'b1, 4'h2, 4'h0, b));
    chk("sp", 32'h2, {28'h0, status.sp});
    rd(4'h1, a);
    // Unsigned then signed multiply
    p = {16'h0, a} * {16'h0, b};
    ex(w(`CID_OP_MULT_U, 1'b0, 4'h1, 4'h2, 16'h0));
    chk("md", p, {status.md_hi, status.md_lo});
    p = $signed(a) * $signed(b);
    ex(w(`CID_OP_MULT_S, 1'b0, 4'h1, 4'h2, 16'h0));
    chk("md", p, {status.md_hi, status.md_lo});
    q = p[15:0] / a;
    r = p[15:0] % a;
    ex(w(`CID_OP_DIVIDE_U, 1'b0, 4'h1, 4'h0, 16'h0));
    chk("md", {r, q}, {status.md_hi, status.md_lo});
    // Zero divisor keeps the pair and raises overflow
    ex(w(`CID_OP_DIVIDE_U, 1'b0, 4'h4, 4'h0, 16'h0));
    chk("md", {r, q}, {status.md_hi, status.md_lo});
    chk("v", 32'h1, {31'h0, status.flags.v});
    p = {r, q} / {16'h0, a};
    q = 16'({r, q} % {16'h0, a});
    ex(w(`CID_OP_LDIVIDE_U, 1'b0, 4'h1, 4'h0, 16'h0));
    chk("md", {q, p[15:0]}, {status.md_hi, status.md_lo});
    a = $signed(a) >>> b[3:0];
    ex(w(`CID_OP_SHR_ARITH, 1'b0, 4'h1, 4'h2, 16'h0));
    rd(4'h1, a);
    n = 16'h0;
    for (int j = 0; j < 16; j++) begin
      if (a[j]) begin
        n = 16'(15 - j);
      end
    end
    ex(w(`CID_OP_NORM, 1'b0, 4'h4, 4'h1, 16'h0));
    rd(4'h4, n);
    // Sleep opcode: long form does nothing, short form is refused
    ex(w(`CID_OP_SLEEP, 1'b1, 4'h1, 4'h1, 16'hFFFF));
    rd(4'h1, a);
    exj(w(`CID_OP_SLEEP, 1'b0, 4'h1, 4'h1, 16'hFFFF), 1'b1, 1'b0, pc + 16'h0002);
    ex(w(`CID_OP_ACC_LOAD, 1'b1, 4'h1, 4'h0, b));
    chk("acc", {b, a}, status.acc);
    ex(w(`CID_OP_EXT_PAGE, 1'b1, 4'h2, 4'h0, 16'h03A5));
    chk("ext", {19'h0, 3'h3, 10'h3A5}, {19'h0, status.ext_left, status.ext_page});
    // Clock enable low holds the fetch off until released
    fork
      ex(w(`CID_OP_NOP, 1'b0, 4'h0, 4'h0, 16'h0));
      begin
        @(posedge clk);
        #1;
        ce = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        ce = 1'b1;
      end
    join
    chk("ext_left", 32'h2, {29'h0, status.ext_left});
    sgt = 16'($urandom);
    seg = sgt[7:0];
    exj(w(`CID_OP_SEG_JUMP, 1'b1, sgt[3:0], sgt[7:4], b), 1'b0, 1'b0, b);
    num = 7'($urandom);
    seg = 8'h00;
    exj(w(`CID_OP_TRAP, 1'b0, num[3:0], {1'b0, num[6:4]}, 16'h0), 1'b0, 1'b1,
      {7'h0, num, 2'b00});
    chk("sp", 32'h3, {28'h0, status.sp});
    // Set one bit by field write, branch on it once, then fall through
    ex(w(`CID_OP_FIELD_LO, 1'b1, 4'h6, 4'h0, 16'h0404));
    exj(w(`CID_OP_BR_BIT_CLR, 1'b1, 4'h6, 4'h2, 16'h0010), 1'b0, 1'b0, pc + 16'h0024);
    ex(w(`CID_OP_BR_BIT_CLR, 1'b1, 4'h6, 4'h2, 16'h0010));
    // Call then immediate return on back-to-back edges
    notes.push_back({3'h4, 3'h4, seg, b});
    notes.push_back({3'h4, 3'h2, seg, pc + 16'h0004});
    pc = pc + 16'h0004;
    cid_fetch_model_inst.send2(w(`CID_OP_PUSH_CALL, 1'b1, 4'h1, 4'h0, b),
      w(`CID_OP_RETURN_POP, 1'b0, 4'h5, 4'h0, 16'h0), ok2);
    if (!ok2) begin
      num_errors++;
      stop_test();
    end
    @(negedge clk);
    #1;
    chk("sp", 32'h3, {28'h0, status.sp});
    rd(4'h5, a);
    repeat (2) @(posedge clk);
    stop_test();
  end
endmodule
